/* core/mcp_pkg.sv */
// package of constants and types for the module control pin decoder
package mcp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] MCP_ADDR_CTRL      = 4'h0;
  localparam logic [3:0] MCP_ADDR_TXLIM     = 4'h1;
  localparam logic [3:0] MCP_ADDR_TUNER     = 4'h2;
  localparam logic [3:0] MCP_ADDR_STATUS    = 4'h3;

  // ctrl fields
  localparam int         MCP_CTRL_RADIO_EN  = 0;
  localparam int         MCP_CTRL_TUNER_MIPI = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic       MCP_RST_RADIO_EN   = 1'b1;
  localparam logic [7:0] MCP_RST_TX_DEFAULT = 8'hFF;
  localparam logic [7:0] MCP_RST_TX_REDUCED = 8'h80;
  localparam logic [3:0] MCP_RST_TUNER_GPO  = 4'h0;

  // module-type straps: only the second one is tied to ground
  localparam logic [3:0] MCP_STRAP_DRIVE_N  = 4'hD;
  localparam logic [3:0] MCP_STRAP_LEVEL    = 4'h0;

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    MCP_ST_RESET = 2'b00,
    MCP_ST_SYNC  = 2'b01,
    MCP_ST_CAPT  = 2'b11,
    MCP_ST_RUN   = 2'b10
  } mcp_state_t;

endpackage : mcp_pkg

/* core/mcp_decoder.sv */
// decoder of the module's static host control pins and straps
//
// What this block does
// - rf kill low disables radio, flight mode; high enables radio.
// - host command may also switch the radio enable state.
// - body proximity low caps transmit power at configured threshold.
// - body proximity high keeps the default transmit power limit.
// - host sets the reduced transmit power threshold by command.
// - boot select high picks usb boot, otherwise pcie early boot.
// - antenna select high means dual antennas, low means four antennas.
// - tuner driven as four gpo bits; mipi mode holds the rffe clock/data link idle low.
// - second module-type strap tied to ground, other three left open.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module mcp_decoder
#(
  parameter int TX_W = 8
) (
  input  wire  logic              clk,
  input  wire  logic              rst_b,
  input  wire  logic [3:0]        reg_addr,
  input  wire  logic [15:0]       reg_wdata,
  input  wire  logic              reg_wr,
  input  wire  logic              reg_rd,
  output logic       [15:0]       reg_rdata,
  input  wire  logic              rf_kill_n,
  input  wire  logic              body_proximity_n,
  input  wire  logic              boot_usb_select,
  input  wire  logic              antenna_count_select,
  output logic                    radio_enable,
  output logic                    flight_mode,
  output logic       [TX_W-1:0]   tx_power_limit,
  output logic                    boot_usb,
  output logic                    antenna_four,
  output logic                    tuner_gpo_bit0,
  output logic                    tuner_gpo_bit1,
  output logic                    tuner_gpo_bit2,
  output logic                    tuner_gpo_bit3,
  output logic                    rffe_sclk,
  output logic                    rffe_sdata_out,
  output logic                    rffe_sdata_oe_n,
  output logic       [3:0]        strap_level,
  output logic       [3:0]        strap_oe_n
);
  import mcp_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // both threshold fields are eight bits wide in the register word
  if (TX_W != 8) begin : g_bad_tx_w
    $error("mcp_decoder: TX_W must be 8");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    mcp_state_t       st;
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic             radio_cmd;
    logic             tuner_mipi;
    logic [TX_W-1:0]  tx_def;
    logic [TX_W-1:0]  tx_red;
    logic [3:0]       gpo;
    logic             boot_usb;
    logic             ant_four;
    logic             radio_en;
    logic             flight;
    logic [TX_W-1:0]  tx_lim;
    logic [3:0]       gpo_out;
    logic             sclk;
    logic             sdata;
    logic             oe_n;
    logic [15:0]      rdata;
  } mcp_regs_t;

  mcp_regs_t r_q;
  mcp_regs_t r_d;

  // synchronisers reset low: radio stays off, and from the first clock after reset power is capped
  // until real pin levels have come through both stages
  localparam mcp_regs_t MCP_RST = '{
    st:         MCP_ST_RESET,
    s1:         4'h0,
    s2:         4'h0,
    radio_cmd:  MCP_RST_RADIO_EN,
    tuner_mipi: 1'b0,
    tx_def:     MCP_RST_TX_DEFAULT,
    tx_red:     MCP_RST_TX_REDUCED,
    gpo:        MCP_RST_TUNER_GPO,
    boot_usb:   1'b0,
    ant_four:   1'b0,
    radio_en:   1'b0,
    flight:     1'b1,
    tx_lim:     MCP_RST_TX_DEFAULT,
    gpo_out:    MCP_RST_TUNER_GPO,
    sclk:       1'b0,
    sdata:      1'b0,
    oe_n:       1'b1,
    rdata:      16'h0000
  };

  // ************************************************************
  // helpers
  // ************************************************************
  // radio runs only when the kill pin and the host command both allow it
  function automatic logic radio_allowed(input logic pin_on, input logic cmd_on);
    return pin_on & cmd_on;
  endfunction : radio_allowed

  // status word; bits 7:6 are spare and read as zero
  function automatic logic [15:0] status_word(input mcp_regs_t r);
    return {r.tx_lim, 2'b00, r.ant_four, r.boot_usb,
            ~r.s2[1], r.s2[0], r.flight, r.radio_en};
  endfunction : status_word

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    r_d       = r_q;
    r_d.rdata = 16'h0000;
    // two-stage synchroniser; s1 feeds only s2
    r_d.s1 = {antenna_count_select, boot_usb_select, body_proximity_n, rf_kill_n};
    r_d.s2 = r_q.s1;

    // straps are sampled once after reset and then held, as hardware straps are;
    // capture waits until both synchroniser stages hold real pin levels,
    // otherwise the reset value of the stages would be latched instead
    case (r_q.st)
      MCP_ST_RESET: r_d.st = MCP_ST_SYNC;
      MCP_ST_SYNC:  r_d.st = MCP_ST_CAPT;
      MCP_ST_CAPT: begin
        r_d.boot_usb = r_q.s2[2];
        r_d.ant_four = ~r_q.s2[3];
        r_d.st       = MCP_ST_RUN;
      end
      MCP_ST_RUN: r_d.st = MCP_ST_RUN;
      default: r_d.st = MCP_ST_RESET;
    endcase

    // **********************************************************
    // host register writes
    // **********************************************************
    if (reg_wr) begin
      if (reg_addr == MCP_ADDR_CTRL) begin
        r_d.radio_cmd  = reg_wdata[MCP_CTRL_RADIO_EN];
        r_d.tuner_mipi = reg_wdata[MCP_CTRL_TUNER_MIPI];
      end else if (reg_addr == MCP_ADDR_TXLIM) begin
        r_d.tx_def = reg_wdata[7:0];
        r_d.tx_red = reg_wdata[15:8];
      end else if (reg_addr == MCP_ADDR_TUNER) begin
        r_d.gpo = reg_wdata[3:0];
      end
    end

    // **********************************************************
    // pin decode
    // **********************************************************
    // radio needs both the pin and the command to allow it
    r_d.radio_en = radio_allowed(r_q.s2[0], r_q.radio_cmd);
    r_d.flight   = ~radio_allowed(r_q.s2[0], r_q.radio_cmd);
    // reduced threshold only ever lowers the cap
    if (!r_q.s2[1] && (r_q.tx_red < r_q.tx_def)) begin
      r_d.tx_lim = r_q.tx_red;
    end else begin
      r_d.tx_lim = r_q.tx_def;
    end

    // gpo mode drives the four bits; mipi mode parks them low
    r_d.gpo_out = r_q.tuner_mipi ? 4'h0 : r_q.gpo;
    r_d.sclk    = 1'b0;
    r_d.sdata   = 1'b0; // limitation: rffe link is idle, no sequencer
    // registered beside gpo_out so the data pin and the gpo bits swap in one edge
    r_d.oe_n    = ~r_q.tuner_mipi;

    // **********************************************************
    // host register reads
    // **********************************************************
    if (reg_rd) begin
      if (reg_addr == MCP_ADDR_CTRL) begin
        r_d.rdata = {14'h0000, r_q.tuner_mipi, r_q.radio_cmd};
      end else if (reg_addr == MCP_ADDR_TXLIM) begin
        r_d.rdata = {r_q.tx_red, r_q.tx_def};
      end else if (reg_addr == MCP_ADDR_TUNER) begin
        r_d.rdata = {12'h000, r_q.gpo};
      end else if (reg_addr == MCP_ADDR_STATUS) begin
        r_d.rdata = status_word(r_q);
      end else begin
        r_d.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= MCP_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata       = r_q.rdata;
  assign radio_enable    = r_q.radio_en;
  assign flight_mode     = r_q.flight;
  assign tx_power_limit  = r_q.tx_lim;
  assign boot_usb        = r_q.boot_usb;
  assign antenna_four    = r_q.ant_four;
  assign tuner_gpo_bit0  = r_q.gpo_out[0];
  assign tuner_gpo_bit1  = r_q.gpo_out[1];
  assign tuner_gpo_bit2  = r_q.gpo_out[2];
  assign tuner_gpo_bit3  = r_q.gpo_out[3];
  assign rffe_sclk       = r_q.sclk;
  assign rffe_sdata_out  = r_q.sdata;
  assign rffe_sdata_oe_n = r_q.oe_n;
  // straps are fixed wiring of the module, not state
  assign strap_level     = MCP_STRAP_LEVEL;
  assign strap_oe_n      = MCP_STRAP_DRIVE_N;

endmodule : mcp_decoder

/* bench/mcp_host_model.sv */
// host platform model that drives the static control pins
module mcp_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] want,
  output logic      [3:0] pin = 4'h7
);
  timeunit 1ns / 1ps;
  // bit2 high is the usb pull-up, low is the floating pin held by the pull-down
  always @(posedge clk) pin <= want;
endmodule : mcp_host_model

/* bench/mcp_decoder_assertions.sv */
// port checker for the control pin decoder
module mcp_chk
  import mcp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rf_kill_n,
  input wire logic        radio_enable,
  input wire logic        flight_mode,
  input wire logic        rffe_sdata_oe_n,
  input wire logic        tuner_gpo_bit0,
  input wire logic [3:0]  strap_level,
  input wire logic [3:0]  strap_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_off; reg_wr && reg_addr == MCP_ADDR_CTRL && !reg_wdata[0]; endsequence
  sequence s_st; reg_rd && reg_addr == MCP_ADDR_STATUS; endsequence
  property p_flt; flight_mode == !radio_enable; endproperty
  a_flt: assert property (p_flt) else $error("flight not inverse of radio");
  // two sync stages plus one output register
  property p_kill; !rf_kill_n |-> ##3 !radio_enable; endproperty
  a_kill: assert property (p_kill) else $error("kill pin ignored");
  property p_cmd; s_off |-> ##2 !radio_enable; endproperty
  a_cmd: assert property (p_cmd) else $error("radio command ignored");
  property p_stat; s_st |=> reg_rdata[1:0] == {$past(flight_mode), $past(radio_enable)}; endproperty
  a_stat: assert property (p_stat) else $error("status radio bits wrong");
  property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_unmap; reg_rd && reg_addr > MCP_ADDR_STATUS |=> reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_strap; strap_oe_n == MCP_STRAP_DRIVE_N && strap_level == 4'h0; endproperty
  a_strap: assert property (p_strap) else $error("strap drive wrong");
  property p_tun; !rffe_sdata_oe_n |-> !tuner_gpo_bit0; endproperty
  a_tun: assert property (p_tun) else $error("gpo active in link mode");
endmodule : mcp_chk

/* bench/mcp_decoder_tb_top.sv */
// testbench for the control pin decoder
module mcp_decoder_tb_top;
  import mcp_pkg::*;
  timeunit 1ns / 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, want = 4'h7, pin, strap_level, strap_oe_n, gpo;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0]  tx_power_limit;
  logic        radio_enable, flight_mode, boot_usb, antenna_four, rffe_sclk, rffe_sdata_out;
  logic        rffe_sdata_oe_n, tuner_gpo_bit0, tuner_gpo_bit1, tuner_gpo_bit2, tuner_gpo_bit3;
  int          err_total = 0, compares = 0;
  assign gpo = {tuner_gpo_bit3, tuner_gpo_bit2, tuner_gpo_bit1, tuner_gpo_bit0};
  mcp_host_model mcp_host_model_inst (.clk, .want, .pin);
  mcp_decoder mcp_decoder_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rf_kill_n(pin[0]), .body_proximity_n(pin[1]), .boot_usb_select(pin[2]),
    .antenna_count_select(pin[3]), .radio_enable, .flight_mode, .tx_power_limit, .boot_usb,
    .antenna_four, .tuner_gpo_bit0, .tuner_gpo_bit1, .tuner_gpo_bit2, .tuner_gpo_bit3,
    .rffe_sclk, .rffe_sdata_out, .rffe_sdata_oe_n, .strap_level, .strap_oe_n);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rd
  // model register plus two sync stages plus output register, with margin
  task automatic pins(input logic [3:0] w);
    @(posedge clk) want <= w;
    repeat (6) @(posedge clk);
    #1;
  endtask : pins
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always #5 clk = ~clk;
  initial begin
    #50000 err_total++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    pins(4'h7);
    chk({boot_usb, antenna_four, radio_enable, flight_mode, gpo}, 8'hE0);
    chk({strap_oe_n, strap_level}, 8'hD0);
    rd(MCP_ADDR_CTRL, 16'hFFFF, 16'h0001);
    rd(MCP_ADDR_TXLIM, 16'hFFFF, 16'h80FF);
    rd(MCP_ADDR_STATUS, 16'hFF3B, 16'hFF31);
    rd(4'hF, 16'hFFFF, 16'h0000);
    $display("test reset done");
    @(posedge clk) want <= 4'h6;
    repeat (3) @(posedge clk);
    #1 chk(radio_enable, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk({radio_enable, flight_mode}, 2'b01);
    pins(4'h7);
    chk({radio_enable, flight_mode}, 2'b10);
    wr(MCP_ADDR_CTRL, 16'h0000);
    @(posedge clk) #1 chk({radio_enable, flight_mode}, 2'b01);
    wr(MCP_ADDR_CTRL, 16'h0001);
    $display("test radio done");
    wr(MCP_ADDR_TXLIM, 16'h40C0);
    pins(4'h7);
    chk(tx_power_limit, 8'hC0);
    pins(4'h5);
    chk({tx_power_limit, boot_usb}, 9'h081);
    pins(4'h7);
    $display("test power done");
    wr(MCP_ADDR_TUNER, 16'h000B);
    pins(4'h7);
    chk({gpo, rffe_sdata_oe_n}, 5'h17);
    wr(MCP_ADDR_CTRL, 16'h0003);
    pins(4'h7);
    chk({gpo, rffe_sdata_oe_n, rffe_sclk, rffe_sdata_out}, 7'h00);
    $display("test tuner done");
    // second reset with the usb pull-up absent and the antenna pin high
    @(posedge clk) {rst_b, want} <= {1'b0, 4'hB};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    pins(4'hB);
    chk({boot_usb, antenna_four, radio_enable, flight_mode}, 4'h2);
    chk(tx_power_limit, 8'hFF);
    chk({gpo, rffe_sdata_oe_n}, 5'h01);
    rd(MCP_ADDR_CTRL, 16'hFFFF, 16'h0001);
    $display("test restrap done");
    test_done();
  end
endmodule : mcp_decoder_tb_top
bind mcp_decoder mcp_chk mcp_chk_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rf_kill_n, .radio_enable, .flight_mode, .rffe_sdata_oe_n, .tuner_gpo_bit0,
  .strap_level, .strap_oe_n);
